//--- rtl/conv_pkg.sv
// Overview of operation
// R01 - Current reads return an unsupported code in reverse flow.
// R02 - Voltage reads in 0.1 V units, refreshed every 100 us.
// R03 - High side current in mA, refreshed every 100 us.
// R04 - Low side current in 10 mA units, refreshed every 100 us.
// R05 - Resistance in 10 uOhm, temperature in degrees, every 100 ms.
// R06 - Disabled unit reads -300 V on the low side voltage.
// R07 - Disabled unit reads -273 degrees on temperature.
// R08 - Limits reset to 100 percent of protection value.
// R09 - Writes need disabled unit, undervoltage and bias; on/off writes here check the bias supply only.
// R10 - Host keeps unit disabled 3 ms after a write.
// R11 - Overvoltage limit write puts lockout 3 percent lower.
// R12 - Undervoltage control only drops to a preset default.
// R13 - Turn-on delay adds 0 to 100 ms, default 0, to start-up.
// R14 - On/off and limit writes need the bias supply.
// R15 - Without bias, telemetry is lost when input goes away.
// R16 - Address sampled once at start-up, then held.
// R17 - Strap 0 to 3.3 V: sixteen 206.25 mV address bands.
// R18 - First undervoltage recovery starts a one-time 20 ms delay.
// R19 - Limits read and write through their limit commands.
// R20 - Writes failing the write conditions are ignored.
package conv_pkg;
  // clock and time bases
  localparam int CLK_PERIOD_NS   = 5;
  localparam int FAST_PERIOD_NS  = 100_000;
  localparam int FAST_CYC        = FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int MS_NS           = 1_000_000;
  localparam int MS_CYC          = MS_NS / CLK_PERIOD_NS;
  localparam int SLOW_PERIOD_MS  = 100;
  localparam int STARTUP_MS      = 20;
  localparam int COMMIT_MS       = 3;
  localparam int TON_MAX_MS      = 100;
  // command codes
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_OT_FAULT  = 8'h4f;
  localparam logic [7:0] CMD_OT_WARN   = 8'h51;
  localparam logic [7:0] CMD_OV_FAULT  = 8'h55;
  localparam logic [7:0] CMD_OV_WARN   = 8'h57;
  localparam logic [7:0] CMD_OC_FAULT  = 8'h5b;
  localparam logic [7:0] CMD_OC_WARN   = 8'h5d;
  localparam logic [7:0] CMD_EXTRA_TURN_ON_DELAY = 8'h60;
  localparam logic [7:0] CMD_RD_HI_V   = 8'h88;
  localparam logic [7:0] CMD_RD_HI_I   = 8'h89;
  localparam logic [7:0] CMD_RD_LO_V   = 8'h8b;
  localparam logic [7:0] CMD_RD_LO_I   = 8'h8c;
  localparam logic [7:0] CMD_RD_TEMP   = 8'h8d;
  localparam logic [7:0] CMD_RD_ROUT   = 8'hd4;
  localparam logic [7:0] CMD_UV_CTRL   = 8'hd7;
  // parameter store indices
  localparam int         NUM_PARAM  = 8;
  localparam logic [3:0] IDX_OV     = 4'h2;
  localparam logic [3:0] IDX_TON    = 4'h6;
  localparam logic [3:0] IDX_UV     = 4'h7;
  localparam logic [3:0] IDX_NONE   = 4'hf;
  // reset values and fixed answers
  localparam logic [15:0] LIMIT_DEFAULT   = 16'h0064;
  localparam logic [15:0] TON_DEFAULT     = 16'h0000;
  localparam logic [15:0] UV_DEFAULT      = 16'h0000;
  localparam logic [15:0] LO_V_DISABLED   = 16'hf448;
  localparam logic [15:0] TEMP_DISABLED   = 16'hfeef;
  localparam logic [15:0] CUR_UNSUPPORTED = 16'h8000;
  localparam logic [15:0] UNMAPPED_READ   = 16'hffff;
  localparam logic [7:0]  OPERATION_RESET = 8'h00;
  localparam int          OVLO_NUM        = 97;
  localparam int          OVLO_DEN        = 100;
  // address strap, band width in quarter millivolts
  localparam int          STRAP_BAND_QMV  = 825;
  localparam int          STRAP_BANDS     = 16;
  localparam logic [6:0]  ADDR_BASE       = 7'h50;

  typedef struct packed {
    logic [15:0] hi_v;
    logic [15:0] hi_i;
    logic [15:0] lo_v;
    logic [15:0] lo_i;
    logic [15:0] rout;
    logic [15:0] temp;
  } telemetry_t;

  typedef struct packed {
    logic [3:0]  idx;
    logic [15:0] data;
  } nvm_write_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ACK  = 3'b010,
    BUS_RX   = 3'b011,
    BUS_TX   = 3'b100,
    BUS_TACK = 3'b101
  } bus_state_t;

  typedef enum logic [1:0] {
    SU_WAIT  = 2'b00,
    SU_DELAY = 2'b01,
    SU_RUN   = 2'b10
  } startup_state_t;
endpackage : conv_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output moves only when stages two and three agree
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // shift chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // per-bit agreement filter
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_agree
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        q_o[g] <= 1'b0;
      end else if (s2_reg[g] == s3_reg[g]) begin
        q_o[g] <= s3_reg[g];
      end
    end
  end
endmodule : pin_sync

//--- rtl/tick_divider.sv
`timescale 1ns/100ps
// one-cycle enable pulse every DIV clocks
module tick_divider #(
  parameter int DIV = 2
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  output logic      tick_o
);
  logic [31:0] cnt_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnt_reg <= '0;
      tick_o  <= 1'b0;
    end else if (cnt_reg == 32'(DIV - 1)) begin
      cnt_reg <= '0;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'd1;
      tick_o  <= 1'b0;
    end
  end
endmodule : tick_divider

//--- rtl/converter_pmbus_telemetry_config.sv
`timescale 1ns/100ps
module converter_pmbus_telemetry_config #(
  parameter int FAST_DIV = conv_pkg::FAST_CYC,
  parameter int MS_DIV   = conv_pkg::MS_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  input  wire logic [11:0]          addr_strap_mv_i,
  input  wire logic                 unit_enabled_i,
  input  wire logic                 reverse_flow_i,
  input  wire logic                 hi_below_uv_i,
  input  wire logic                 hi_above_uv_recovery_i,
  input  wire logic                 external_bias_supply_i,
  input  wire logic                 input_present_i,
  input  wire conv_pkg::telemetry_t meas_i,
  output conv_pkg::nvm_write_t      nvm_write_o,
  output logic                      nvm_write_valid_o,
  output logic                      nvm_busy_o,
  output logic [15:0]               overvoltage_lockout_o,
  output logic                      uv_protect_default_o,
  output logic                      operation_on_o,
  output logic                      powertrain_start_o,
  output logic [6:0]                target_addr_o
);
  import conv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning and time bases
  logic [7:0]  pins_s;
  logic [11:0] strap_s;
  logic        scl_s;
  logic        sda_s;
  logic        en_s;
  logic        rev_s;
  logic        uv_s;
  logic        recov_s;
  logic        bias_s;
  logic        inp_s;
  logic        fast_tick;
  logic        ms_tick;

  pin_sync #(.WIDTH(8)) u_pin_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({scl_i, sda_i, unit_enabled_i, reverse_flow_i, hi_below_uv_i,
                 hi_above_uv_recovery_i, external_bias_supply_i, input_present_i}),
    .q_o       (pins_s)
  );

  pin_sync #(.WIDTH(12)) u_strap_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (addr_strap_mv_i),
    .q_o       (strap_s)
  );

  assign {scl_s, sda_s, en_s, rev_s, uv_s, recov_s, bias_s, inp_s} = pins_s;

  tick_divider #(.DIV(FAST_DIV)) u_fast_tick (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (fast_tick)
  );

  tick_divider #(.DIV(MS_DIV)) u_ms_tick (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .tick_o    (ms_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] cmd_index(input logic [7:0] cmd);
    logic [3:0] idx;
    idx = IDX_NONE;
    if (cmd == CMD_OT_FAULT) idx = 4'h0;
    else if (cmd == CMD_OT_WARN) idx = 4'h1;
    else if (cmd == CMD_OV_FAULT) idx = IDX_OV;
    else if (cmd == CMD_OV_WARN) idx = 4'h3;
    else if (cmd == CMD_OC_FAULT) idx = 4'h4;
    else if (cmd == CMD_OC_WARN) idx = 4'h5;
    else if (cmd == CMD_EXTRA_TURN_ON_DELAY) idx = IDX_TON;
    else if (cmd == CMD_UV_CTRL) idx = IDX_UV;
    return idx;
  endfunction : cmd_index

  // highest band whose lower edge the strap level has reached
  function automatic logic [3:0] strap_band(input logic [11:0] mv);
    logic [3:0] band;
    band = 4'h0;
    for (int i = 1; i < STRAP_BANDS; i++) begin
      if ({mv, 2'b00} >= 14'(i * STRAP_BAND_QMV)) band = 4'(i); // [R17]
    end
    return band;
  endfunction : strap_band

  ////////////////////////////////////////////////////////////////////////////
  // target address, caught once after reset and then frozen
  logic       addr_locked_reg;
  logic [6:0] addr_reg;

  // waits one ms tick so the strap has settled before it is read
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      addr_locked_reg <= 1'b0;
      addr_reg        <= ADDR_BASE;
    end else if (ms_tick && !addr_locked_reg) begin
      addr_locked_reg <= 1'b1; // [R16]
      addr_reg        <= ADDR_BASE | {3'b000, strap_band(strap_s)};
    end
  end

  assign target_addr_o = addr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // telemetry snapshots
  telemetry_t tel_reg;
  logic [6:0] slow_cnt_reg;
  logic       lost_power;

  assign lost_power = !bias_s && !inp_s;

  // fast channels on 100 us, slow channels every 100 ms
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tel_reg      <= '0;
      slow_cnt_reg <= '0;
    end else if (lost_power) begin
      tel_reg      <= '0; // [R15]
      slow_cnt_reg <= '0;
    end else begin
      if (fast_tick) begin
        tel_reg.hi_v <= meas_i.hi_v; // [R02]
        tel_reg.lo_v <= meas_i.lo_v; // [R02]
        tel_reg.hi_i <= meas_i.hi_i; // [R03]
        tel_reg.lo_i <= meas_i.lo_i; // [R04]
      end
      if (ms_tick) begin
        if (slow_cnt_reg == 7'(SLOW_PERIOD_MS - 1)) begin
          slow_cnt_reg <= '0;
          tel_reg.rout <= meas_i.rout; // [R05]
          tel_reg.temp <= meas_i.temp; // [R05]
        end else begin
          slow_cnt_reg <= slow_cnt_reg + 7'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word selection
  logic [15:0] param_mem [NUM_PARAM];
  logic [7:0]  op_reg;
  logic [7:0]  cmd_reg;
  logic [15:0] rd_word;
  logic [3:0]  rd_idx;

  assign rd_idx = cmd_index(cmd_reg);

  always_comb begin
    if (cmd_reg == CMD_RD_HI_V) rd_word = tel_reg.hi_v;
    else if (cmd_reg == CMD_RD_HI_I) rd_word = rev_s ? CUR_UNSUPPORTED : tel_reg.hi_i; // [R01]
    else if (cmd_reg == CMD_RD_LO_V) rd_word = en_s ? tel_reg.lo_v : LO_V_DISABLED; // [R06]
    else if (cmd_reg == CMD_RD_LO_I) rd_word = rev_s ? CUR_UNSUPPORTED : tel_reg.lo_i; // [R01]
    else if (cmd_reg == CMD_RD_TEMP) rd_word = en_s ? tel_reg.temp : TEMP_DISABLED; // [R07]
    else if (cmd_reg == CMD_RD_ROUT) rd_word = tel_reg.rout;
    else if (cmd_reg == CMD_OPERATION) rd_word = {8'h00, op_reg};
    else if (rd_idx != IDX_NONE) rd_word = param_mem[rd_idx[2:0]]; // [R19]
    else rd_word = UNMAPPED_READ;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire target engine
  bus_state_t state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic       got8_reg;
  logic       rw_reg;
  logic       nack_reg;
  logic       rd_hi_reg;
  logic       scl_q_reg;
  logic       sda_q_reg;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_q_reg <= 1'b0;
      sda_q_reg <= 1'b0;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_q_reg;
  assign scl_fall  = !scl_s && scl_q_reg;
  assign bus_start = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign bus_stop  = scl_s && scl_q_reg && !sda_q_reg && sda_s;

  // byte framing; the address is matched only once it has been locked
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg    <= BUS_IDLE;
      shift_reg    <= '0;
      tx_reg       <= '0;
      lo_reg       <= '0;
      hi_reg       <= '0;
      cmd_reg      <= '0;
      bit_cnt_reg  <= '0;
      byte_cnt_reg <= '0;
      got8_reg     <= 1'b0;
      rw_reg       <= 1'b0;
      nack_reg     <= 1'b0;
      rd_hi_reg    <= 1'b0;
    end else if (bus_start) begin
      state_reg    <= BUS_ADDR;
      bit_cnt_reg  <= '0;
      byte_cnt_reg <= '0;
      got8_reg     <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= BUS_IDLE;
    end else begin
      case (state_reg)
        BUS_ADDR, BUS_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            got8_reg    <= (bit_cnt_reg == 3'd7);
          end else if (scl_fall && got8_reg) begin
            got8_reg <= 1'b0;
            if (state_reg == BUS_ADDR) begin
              rw_reg    <= shift_reg[0];
              state_reg <= (addr_locked_reg && shift_reg[7:1] == addr_reg) ? BUS_ACK : BUS_IDLE;
            end else begin
              if (byte_cnt_reg == 2'd0) cmd_reg <= shift_reg;
              if (byte_cnt_reg == 2'd1) lo_reg <= shift_reg;
              if (byte_cnt_reg == 2'd2) hi_reg <= shift_reg;
              if (byte_cnt_reg != 2'd3) byte_cnt_reg <= byte_cnt_reg + 2'd1;
              state_reg <= BUS_ACK;
            end
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (rw_reg) begin
              state_reg <= BUS_TX;
              tx_reg    <= rd_word[7:0];
              rd_hi_reg <= 1'b1;
            end else begin
              state_reg <= BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            tx_reg      <= {tx_reg[6:0], 1'b1};
            bit_cnt_reg <= bit_cnt_reg + 3'd1;
            if (bit_cnt_reg == 3'd7) state_reg <= BUS_TACK;
          end
        end
        BUS_TACK: begin
          if (scl_rise) begin
            nack_reg <= sda_s;
          end else if (scl_fall) begin
            state_reg <= nack_reg ? BUS_IDLE : BUS_TX;
            tx_reg    <= rd_hi_reg ? rd_word[15:8] : 8'hff;
            rd_hi_reg <= 1'b0;
          end
        end
        default: state_reg <= BUS_IDLE;
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = (state_reg == BUS_ACK) || (state_reg == BUS_TX && !tx_reg[7]);

  ////////////////////////////////////////////////////////////////////////////
  // write commit and parameter store
  logic        wr_fire;
  logic        wr_ok;
  logic [3:0]  wr_idx;
  logic [15:0] wr_word;
  logic [15:0] ton_val;
  logic [2:0]  busy_cnt_reg;
  logic [15:0] ovlo_reg;

  assign wr_fire = bus_stop && state_reg != BUS_IDLE && !rw_reg && byte_cnt_reg >= 2'd2;
  assign wr_ok   = !en_s && uv_s && bias_s; // [R09] [R14]
  assign wr_idx  = cmd_index(cmd_reg);
  assign wr_word = {hi_reg, lo_reg};
  assign ton_val = (wr_word > 16'(TON_MAX_MS)) ? 16'(TON_MAX_MS) : wr_word;

  // on/off control needs bias; a word needs all three bytes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      op_reg <= OPERATION_RESET;
    end else if (wr_fire && cmd_reg == CMD_OPERATION && bias_s) begin
      op_reg <= lo_reg; // [R14]
    end
  end

  assign operation_on_o = op_reg[7];

  // rejected writes leave the store as it was
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_PARAM; i++) param_mem[i] <= LIMIT_DEFAULT; // [R08]
      param_mem[IDX_TON[2:0]] <= TON_DEFAULT; // [R13]
      param_mem[IDX_UV[2:0]]  <= UV_DEFAULT;
      nvm_write_valid_o       <= 1'b0;
      nvm_write_o             <= '0;
    end else begin
      nvm_write_valid_o <= 1'b0;
      if (wr_fire && wr_idx != IDX_NONE && byte_cnt_reg == 2'd3 && wr_ok) begin // [R20]
        if (wr_idx == IDX_TON) param_mem[wr_idx[2:0]] <= ton_val; // [R13]
        else if (wr_idx == IDX_UV) param_mem[wr_idx[2:0]] <= {15'h0000, wr_word[0]}; // [R12]
        else param_mem[wr_idx[2:0]] <= wr_word; // [R19]
        nvm_write_valid_o <= 1'b1;
        nvm_write_o.idx   <= wr_idx;
        nvm_write_o.data  <= (wr_idx == IDX_TON) ? ton_val : wr_word;
      end
    end
  end

  // lockout sits three percent under the written fault limit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovlo_reg <= 16'((32'(LIMIT_DEFAULT) * OVLO_NUM) / OVLO_DEN);
    end else if (wr_fire && wr_idx == IDX_OV && byte_cnt_reg == 2'd3 && wr_ok) begin
      ovlo_reg <= 16'((32'(wr_word) * OVLO_NUM) / OVLO_DEN); // [R11]
    end
  end

  assign overvoltage_lockout_o = ovlo_reg;
  assign uv_protect_default_o  = param_mem[IDX_UV[2:0]][0]; // [R12]

  // commit window; one extra tick since the first may come at once
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      busy_cnt_reg <= '0;
    end else if (nvm_write_valid_o) begin
      busy_cnt_reg <= 3'(COMMIT_MS + 1); // [R10]
    end else if (ms_tick && busy_cnt_reg != 3'd0) begin
      busy_cnt_reg <= busy_cnt_reg - 3'd1;
    end
  end

  assign nvm_busy_o = busy_cnt_reg != 3'd0;

  ////////////////////////////////////////////////////////////////////////////
  // one-time start-up sequencing
  startup_state_t su_state_reg;
  logic [7:0]     su_cnt_reg;
  logic [7:0]     su_target;

  assign su_target = 8'(STARTUP_MS) + param_mem[IDX_TON[2:0]][7:0]; // [R13]

  // counted in ms ticks, so the delay may run up to one ms short
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      su_state_reg <= SU_WAIT;
      su_cnt_reg   <= '0;
    end else begin
      case (su_state_reg)
        SU_WAIT: begin
          if (recov_s) su_state_reg <= SU_DELAY; // [R18]
          su_cnt_reg <= '0;
        end
        SU_DELAY: begin
          if (su_cnt_reg >= su_target) su_state_reg <= SU_RUN; // [R18]
          else if (ms_tick) su_cnt_reg <= su_cnt_reg + 8'd1;
        end
        default: su_state_reg <= SU_RUN;
      endcase
    end
  end

  assign powertrain_start_o = su_state_reg == SU_RUN;
endmodule : converter_pmbus_telemetry_config

//--- test/conv_host.sv
`timescale 1ns/100ps
// two-wire host; one bit is four quarters of QTR clocks
module conv_host #(
  parameter int QTR = 6
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  logic b;
  // released line floats high through the pull-up
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end
  task automatic q();
    repeat (QTR) @(negedge clk_i);
  endtask : q
  // data moves only while the clock is low
  task automatic bit_io(input logic d, output logic s);
    pull_o = ~d;
    q();
    scl_o = 1'b1;
    q();
    s = sda_i;
    q();
    scl_o = 1'b0;
    q();
  endtask : bit_io
  // s high makes a start, low a stop; the stop leaves the clock high
  task automatic frame(input logic s);
    pull_o = ~s;
    q();
    scl_o = 1'b1;
    q();
    pull_o = s;
    q();
    scl_o = ~s;
    q();
  endtask : frame
  task automatic send(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_io(v[i], b);
    bit_io(1'b1, b);
  endtask : send
  task automatic recv(input logic last, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(last, b);
  endtask : recv
  // word write, low byte first
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d);
    frame(1'b1);
    send({a, 1'b0});
    send(c);
    send(d[7:0]);
    send(d[15:8]);
    frame(1'b0);
  endtask : wr
  // word read via repeated start, nack on the last byte
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d);
    frame(1'b1);
    send({a, 1'b0});
    send(c);
    frame(1'b1);
    send({a, 1'b1});
    recv(1'b0, d[7:0]);
    recv(1'b1, d[15:8]);
    frame(1'b0);
  endtask : rd
endmodule : conv_host

//--- test/conv_assertions.sv
`timescale 1ns/100ps
module conv_assertions
  import conv_pkg::*;
#(
  parameter int MS_DIV = 50
) (
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 unit_enabled_i,
  input wire logic                 hi_below_uv_i,
  input wire logic                 hi_above_uv_recovery_i,
  input wire logic                 external_bias_supply_i,
  input wire conv_pkg::nvm_write_t nvm_write_o,
  input wire logic                 nvm_write_valid_o,
  input wire logic                 nvm_busy_o,
  input wire logic [15:0]          overvoltage_lockout_o,
  input wire logic                 powertrain_start_o,
  input wire logic [6:0]           target_addr_o
);
  int busy_cnt, rec_cnt, up_cnt;
  // busy length, time since recovery, time since reset
  always_ff @(posedge clk_i) busy_cnt <= (sys_rst_i || !nvm_busy_o) ? 0 : busy_cnt + 1;
  always_ff @(posedge clk_i) rec_cnt <= (sys_rst_i || !(hi_above_uv_recovery_i || rec_cnt != 0)) ? 0 : rec_cnt + 1;
  always_ff @(posedge clk_i) up_cnt <= sys_rst_i ? 0 : up_cnt + int'(up_cnt < 4 * MS_DIV);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);
  commit_pulse_a: assert property (
    nvm_write_valid_o |=> nvm_busy_o && !nvm_write_valid_o) else $error("commit pulse");
  commit_len_a: assert property (
    $fell(nvm_busy_o) |-> busy_cnt >= 3 * MS_DIV && busy_cnt <= 5 * MS_DIV) else $error("commit window length");
  write_gate_a: assert property (
    nvm_write_valid_o |-> !unit_enabled_i && hi_below_uv_i && external_bias_supply_i) else $error("write gate");
  ovlo_ratio_a: assert property (
    nvm_write_valid_o && nvm_write_o.idx == IDX_OV |=>
    overvoltage_lockout_o == 16'((32'($past(nvm_write_o.data)) * 97) / 100)) else $error("lockout point wrong");
  start_hold_a: assert property (powertrain_start_o |=> powertrain_start_o) else $error("start dropped");
  start_wait_a: assert property (
    $rose(powertrain_start_o) |-> rec_cnt >= 19 * MS_DIV) else $error("start too early");
  addr_base_a: assert property (target_addr_o[6:4] == 3'h5) else $error("address outside range");
  addr_fixed_a: assert property (
    up_cnt >= 2 * MS_DIV |-> $stable(target_addr_o)) else $error("address moved");
endmodule : conv_assertions
bind converter_pmbus_telemetry_config conv_assertions #(.MS_DIV(MS_DIV)) CHK (.*);

//--- test/converter_pmbus_telemetry_config_bench.sv
`timescale 1ns/100ps
module converter_pmbus_telemetry_config_bench;
  import conv_pkg::*;
  localparam int         MD      = 50;
  localparam logic [6:0] DEV     = 7'h5d;
  localparam logic [7:0] LIM [6] = '{8'h4f, 8'h51, 8'h55, 8'h57, 8'h5b, 8'h5d};
  localparam logic [2:0] BAD [3] = '{3'h7, 3'h1, 3'h2};
  logic        clk_i, sys_rst_i, scl, pull, sda, sda_o, sda_oe_o;
  logic        en, rev, blw, rec, bias, inp, nvm_write_valid_o, busy, uvd, opon, pts;
  logic [11:0] strap;
  logic [15:0] ovlo, d;
  logic [6:0]  taddr;
  telemetry_t  meas;
  nvm_write_t  nvw;
  int          bad_count = 0, tests_run = 0;
  // open-drain data line with pull-up
  assign sda = ~(sda_oe_o | pull);
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  converter_pmbus_telemetry_config #(.FAST_DIV(20), .MS_DIV(MD)) DUT (.*, .scl_i(scl), .sda_i(sda),
    .addr_strap_mv_i(strap), .unit_enabled_i(en), .reverse_flow_i(rev), .hi_below_uv_i(blw),
    .hi_above_uv_recovery_i(rec), .external_bias_supply_i(bias), .input_present_i(inp), .meas_i(meas),
    .nvm_write_o(nvw), .nvm_busy_o(busy), .overvoltage_lockout_o(ovlo),
    .uv_protect_default_o(uvd), .operation_on_o(opon), .powertrain_start_o(pts), .target_addr_o(taddr));
  conv_host HOST (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic rdc(input string n, input logic [7:0] c, input logic [15:0] e);
    HOST.rd(DEV, c, d);
    check(n, d, e);
  endtask : rdc
  // synchronised levels need time to land
  task automatic cond(input logic e, input logic b, input logic v);
    @(negedge clk_i);
    en   = e;
    blw  = b;
    bias = v;
    repeat (10) @(negedge clk_i);
  endtask : cond
  task automatic idle();
    for (int n = 0; n < 8 * MD && busy !== 1'b0; n++) @(negedge clk_i);
    if (busy !== 1'b0) begin
      bad_count++;
      finish_test();
    end
  endtask : idle
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 6; i++) rdc("limit", LIM[i], 16'h0064);
    rdc("delay", 8'h60, 16'h0000);
    check("lockout", ovlo, 16'h0061);
    check("addr", 16'(taddr), 16'(DEV));
  endtask : t_reset
  task automatic t_tele();
    rdc("lo_v off", 8'h8b, 16'hf448);
    rdc("temp off", 8'h8d, 16'hfeef);
    cond(1'b1, 1'b1, 1'b1);
    meas = {16'h0fa0, 16'h0bb8, 16'h01f6, 16'h0dac, 16'h0190, 16'h0019};
    repeat (101 * MD) @(negedge clk_i);
    rdc("hi_v", 8'h88, meas.hi_v);
    rdc("hi_i", 8'h89, meas.hi_i);
    rdc("lo_v", 8'h8b, meas.lo_v);
    rdc("lo_i", 8'h8c, meas.lo_i);
    rdc("rout", 8'hd4, meas.rout);
    rdc("temp", 8'h8d, meas.temp);
    rev = 1'b1;
    repeat (60) @(negedge clk_i);
    rdc("hi_i rev", 8'h89, 16'h8000);
    rdc("lo_i rev", 8'h8c, 16'h8000);
    rev = 1'b0;
    cond(1'b0, 1'b1, 1'b0);
    rdc("no bias", 8'h88, meas.hi_v);
    inp = 1'b0;
    repeat (60) @(negedge clk_i);
    rdc("lost", 8'h88, 16'h0000);
    inp = 1'b1;
  endtask : t_tele
  task automatic t_write();
    cond(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < 6; i++) begin
      HOST.wr(DEV, LIM[i], 16'h0050 + 16'(i));
      idle();
      check("nvm", nvw.data, 16'h0050 + 16'(i));
      rdc("limit", LIM[i], 16'h0050 + 16'(i));
    end
    check("lockout", ovlo, 16'h004f);
    HOST.wr(DEV, 8'h60, 16'h0005);
    idle();
    rdc("delay", 8'h60, 16'h0005);
    HOST.wr(DEV, 8'hd7, 16'h0001);
    idle();
    check("uv default", 16'(uvd), 16'h0001);
    cond(1'b0, 1'b1, 1'b0);
    HOST.wr(DEV, 8'h01, 16'h0080);
    check("op no bias", 16'(opon), 16'h0000);
    cond(1'b0, 1'b1, 1'b1);
    HOST.wr(DEV, 8'h01, 16'h0080);
    check("op on", 16'(opon), 16'h0001);
    rdc("op rd", 8'h01, 16'h0080);
  endtask : t_write
  task automatic t_refuse();
    for (int i = 0; i < 3; i++) begin
      cond(BAD[i][2], BAD[i][1], BAD[i][0]);
      HOST.wr(DEV, 8'h57, 16'h0033);
      check("busy", 16'(busy), 16'h0000);
      rdc("kept", 8'h57, 16'h0053);
    end
  endtask : t_refuse
  task automatic t_addr();
    @(negedge clk_i);
    strap = 12'h000;
    repeat (4 * MD) @(negedge clk_i);
    check("addr", 16'(taddr), 16'(DEV));
    HOST.rd(7'h50, 8'h88, d);
    check("other addr", d, 16'hffff);
  endtask : t_addr
  task automatic t_start();
    int n;
    cond(1'b0, 1'b0, 1'b1);
    rec = 1'b1;
    for (n = 0; n < 30 * MD && pts !== 1'b1; n++) @(negedge clk_i);
    check("start late", 16'(n >= 24 * MD), 16'h0001);
    check("started", {15'h0000, pts}, 16'h0001);
  endtask : t_start
  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst_i = 1'b1;
    strap     = 12'ha7a;
    {en, rev, blw, rec, bias, inp} = 6'h0b;
    meas      = '0;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (3 * MD) @(negedge clk_i);
    t_reset();
    t_tele();
    t_write();
    t_refuse();
    t_addr();
    t_start();
    finish_test();
  end
endmodule : converter_pmbus_telemetry_config_bench
